//--- testbench/test_uerf_rx_fifo.sv
// Self-checking bench of the endpoint receive FIFO
`default_nettype none
`include "uerf_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module test_uerf_rx_fifo;
  timeunit 1ns;
  timeprecision 1ps;
  import uerf_pkg::*;
  localparam logic [5:0] i_dat = `UERF_IDX_DATA;
  localparam logic [5:0] i_ctl = `UERF_IDX_CTRL;
  localparam logic [5:0] i_flg = `UERF_IDX_FLAGS;
  localparam logic [5:0] i_cnt = `UERF_IDX_COUNT;
  localparam logic [5:0] i_ovw = `UERF_IDX_OVW;
  localparam logic [5:0] i_sel = `UERF_IDX_EPSEL;
  logic                 mclk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [7:0]           avs_address;
  logic [31:0]          avs_writedata, avs_readdata, rd;
  logic [3:0]           avs_byteenable;
  logic [`UERF_EPS-1:0] ep_nak;
  uerf_sil_s            sil;
  logic [7:0]           exp_q [8];
  int                   miscompares, n_compared, n, i;

  uerf_rx_fifo u_uerf_rx_fifo (.mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sil(sil), .ep_nak(ep_nak));
  uerf_sil_model u_uerf_sil_model (.mclk(mclk), .sil(sil));

  // Clock at 40 MHz
  always #12.5 mclk = ~mclk;

  // Counts, verdict and end of run
  task automatic final_report();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd, output logic [31:0] q);
    int k;
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, wd};
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      miscompares++;
      final_report();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w) repeat (2) @(posedge mclk);
  endtask

  // Read a register and compare the whole data word
  task automatic rdck(input logic [5:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 8'h00, rd);
    `CHK(rd, e)
  endtask

  // Expected flag register word
  function automatic logic [31:0] flg(input logic e, f, u, o);
    return {28'h0, e, f, u, o};
  endfunction

  // Random bytes, then the count, then optionally the acknowledge
  task automatic pkt(input logic ep, input int len, input logic ack);
    for (int j = 0; j < len; j++) begin
      exp_q[j] = 8'($urandom);
      u_uerf_sil_model.ev(0, ep, exp_q[j]);
    end
    u_uerf_sil_model.ev(1, ep, 8'(len));
    if (ack) u_uerf_sil_model.ev(2, ep, 8'h00);
  endtask

  // Main sequence
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(84888));
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    rdck(i_flg, flg(1, 0, 0, 0));
    rdck(i_cnt, 32'h0);
    rdck(6'h30, 32'h0);
    $display("test reset done");
    n = $urandom_range(8, 1);
    pkt(1'b0, n, 1'b0);
    rdck(i_flg, flg(0, 0, 0, 0));
    u_uerf_sil_model.ev(2, 1'b0, 8'h00);
    rdck(i_flg, flg(0, 1, 0, 0));
    rdck(i_cnt, 32'(n));
    for (i = 0; i < n; i++) rdck(i_dat, {24'h0, exp_q[i]});
    rdck(i_flg, flg(1, 1, 0, 0));
    bus(1'b0, i_dat, 8'h00, rd);
    rdck(i_flg, flg(1, 1, 1, 0));
    `CHK(ep_nak, 2'b01)
    bus(1'b1, i_flg, 8'h00, rd);
    rdck(i_flg, flg(1, 1, 0, 0));
    bus(1'b1, i_ctl, 8'h10, rd);
    rdck(i_flg, flg(1, 0, 0, 0));
    $display("test packet and underrun done");
    pkt(1'b0, 3, 1'b1);
    u_uerf_sil_model.ev(0, 1'b0, 8'h5a);
    rdck(i_flg, flg(0, 1, 0, 1));
    `CHK(ep_nak, 2'b01)
    for (i = 0; i < 3; i++) rdck(i_dat, {24'h0, exp_q[i]});
    rdck(i_flg, flg(1, 1, 0, 1));
    u_uerf_sil_model.ev(3, 1'b0, 8'h00);
    bus(1'b0, i_flg, 8'h00, rd);
    `CHK({rd[2], rd[0]}, 2'b00)
    $display("test overrun done");
    pkt(1'b0, 2, 1'b1);
    bus(1'b0, i_flg, 8'h00, rd);
    `CHK(rd[2], 1'b0)
    rdck(i_dat, {24'h0, exp_q[0]});
    u_uerf_sil_model.ev(4, 1'b0, 8'h00);
    u_uerf_sil_model.ev(2, 1'b0, 8'h00);
    bus(1'b1, i_ctl, 8'h10, rd);
    bus(1'b0, i_flg, 8'h00, rd);
    `CHK(rd[2], 1'b1)
    bus(1'b1, i_ovw, 8'h00, rd);
    bus(1'b1, i_ctl, 8'h10, rd);
    bus(1'b0, i_flg, 8'h00, rd);
    `CHK(rd[2], 1'b0)
    $display("test setup lock done");
    pkt(1'b0, 4, 1'b1);
    u_uerf_sil_model.ev(0, 1'b0, 8'ha5);
    bus(1'b1, i_ctl, 8'h80, rd);
    rdck(i_flg, flg(1, 0, 0, 0));
    rdck(i_ctl, 32'h0);
    `CHK(ep_nak, 2'b00)
    $display("test flush done");
    pkt(1'b1, 5, 1'b1);
    rdck(i_flg, flg(1, 0, 0, 0));
    bus(1'b1, i_sel, 8'h01, rd);
    rdck(i_cnt, 32'h5);
    rdck(i_dat, {24'h0, exp_q[0]});
    $display("test endpoint select done");
    final_report();
  end
endmodule // test_uerf_rx_fifo
`default_nettype wire

//--- testbench/uerf_sil_model.sv
// Serial side logic model that feeds received bytes and packet events
`default_nettype none
module uerf_sil_model (
  input  wire logic                mclk,
  output var  uerf_pkg::uerf_sil_s sil
);
  timeunit 1ns;
  timeprecision 1ps;
  import uerf_pkg::*;

  initial sil = '0;

  // One event strobe for one cycle; between events the payload is inverted so stale data is never reused
  task automatic ev(input int k, input logic ep, input logic [7:0] v);
    uerf_sil_s s;
    uerf_sil_s idle;
    s = '0;
    idle = '0;
    s.ep = ep;
    s.data = v;
    s.cnt = v[3:0];
    idle.ep = ~ep;
    idle.data = ~v;
    idle.cnt = ~v[3:0];
    case (k)
      0: s.wr = 1'b1;
      1: s.cnt_wr = 1'b1;
      2: s.ack = 1'b1;
      3: s.setup = 1'b1;
      default: s.setup_done = 1'b1;
    endcase
    @(posedge mclk);
    sil <= s;
    @(posedge mclk);
    sil <= idle;
  endtask
endmodule // uerf_sil_model
`default_nettype wire

//--- verilog/uerf_cfg.svh
// Offsets, field positions, sizes and reset values of the endpoint receive FIFO
`ifndef UERF_CFG_SVH
`define UERF_CFG_SVH

// Sizes
`define UERF_EPS        2
`define UERF_EP_W       1
`define UERF_DEPTH      8
`define UERF_PTR_FULL   4'h8

// Register indices; byte address is four times the index
`define UERF_IDX_DATA   6'h18
`define UERF_IDX_CTRL   6'h19
`define UERF_IDX_FLAGS  6'h1a
`define UERF_IDX_COUNT  6'h1b
`define UERF_IDX_OVW    6'h1c
`define UERF_IDX_EPSEL  6'h07

// Control field positions
`define UERF_CTRL_FLUSH 7
`define UERF_CTRL_DONE  4

// Flag field positions
`define UERF_FLG_EMPTY  3
`define UERF_FLG_FULL   2
`define UERF_FLG_URF    1
`define UERF_FLG_OVF    0

// Setup overwrite field positions
`define UERF_OVW_START  5
`define UERF_OVW_END    4

// Reset values
`define UERF_RST_DATA   32'h0000_0000
`endif

//--- verilog/uerf_pkg.sv
// Types of the endpoint receive FIFO
`default_nettype none
`include "uerf_cfg.svh"
package uerf_pkg;
  // Serial side logic requests
  typedef struct packed {
    logic                  wr;
    logic [7:0]            data;
    logic                  cnt_wr;
    logic [3:0]            cnt;
    logic                  ack;
    logic                  setup;
    logic                  setup_done;
    logic [`UERF_EP_W-1:0] ep;
  } uerf_sil_s;

  // One endpoint receive FIFO
  typedef struct packed {
    logic [`UERF_DEPTH-1:0][7:0] mem;
    logic [3:0]                  wptr;
    logic [3:0]                  rptr;
    logic [3:0]                  cnt;
    logic                        full;
    logic                        urf;
    logic                        ovf;
    logic                        flush;
    logic                        rdone;
    logic                        setup_overwrite_start;
    logic                        setup_overwrite_end;
  } uerf_ep_s;

  // Whole block state
  typedef struct packed {
    uerf_ep_s [`UERF_EPS-1:0] ep;
    logic [`UERF_EP_W-1:0]    sel;
    logic                     waitrequest;
    logic [31:0]              readdata;
    logic [`UERF_EPS-1:0]     nak;
  } uerf_state_s;
endpackage
`default_nettype wire

//--- verilog/uerf_rx_fifo.sv
// Endpoint indexed USB receive FIFO with Avalon-MM register slave
//
// The Avalon-MM register port is this design's own decision.
`default_nettype none
`include "uerf_cfg.svh"

// How it works
// R1: Data, count, control and flag registers act on the endpoint selected.
// R2: Serial writes advance write pointer, CPU data reads advance read pointer.
// R3: Byte count is four bits, read only, upper bits read zero.
// R4: Serial logic writes count after data; CPU reads count bytes.
// R5: Writing the count never sets the full flag; only acknowledge does.
// R6: Flush empties FIFO, clears all flags but empty, then self clears; the code leaves both setup overwrite flags as they stand.
// R7: Read done clears full flag for the set just read, then self clears.
// R8: CPU reads every byte of the set before setting read done.
// R9: Read done is ignored while either setup overwrite flag is set.
// R10: Empty flag tracks pointers; zero length packet also shows empty.
// R11: Successful reception acknowledge sets the full flag.
// R12: Writing the byte count clears the full flag.
// R13: Read of empty FIFO sets sticky underrun, read pointer stays; write zero clears.
// R14: Serial write while full sets sticky overrun; write zero clears.
// R15: A setup packet clears an overrun flag already set.
// R16: On overrun the write pointer does not advance.
// R17: Underrun or overrun on an endpoint makes it answer NAK.
// R18: Software writes zero to reserved bits, ignores their read value.
// R19: Setup token resets full and read pointer, locked while start overwrite set.
// R20: Firmware clears end overwrite before reading after a setup.
// R21: Each FIFO holds eight bytes per data set.
module uerf_rx_fifo (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output var  logic [31:0]            avs_readdata,
  output var  logic                   avs_waitrequest,
  input  wire uerf_pkg::uerf_sil_s    sil,
  output var  logic [`UERF_EPS-1:0]   ep_nak
);
  import uerf_pkg::*;

  uerf_state_s q;
  uerf_state_s next_q;
  logic        acc;
  logic        wr_ok;

  // Register index hit for a byte address
  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    return (a[7:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // Data set fully read out or nothing received
  function automatic logic is_empty(input uerf_ep_s e);
    return e.rptr >= e.wptr;
  endfunction

  // Bus request is taken at the edge where waitrequest is low
  assign acc   = (avs_read | avs_write) & ~q.waitrequest;
  assign wr_ok = acc & avs_write & avs_byteenable[0];

  // Next state of bus slave and every endpoint
  always_comb begin
    uerf_ep_s e;
    logic     me;
    logic     sme;
    e = '0;
    me = 1'b0;
    sme = 1'b0;
    next_q = q;
    next_q.waitrequest = ~((avs_read | avs_write) & q.waitrequest);
    next_q.readdata = `UERF_RST_DATA;
    // Read data prepared one cycle ahead of the taking edge
    if (avs_read & q.waitrequest) begin
      e = q.ep[q.sel];                                          // [R1]
      if (hit(avs_address, `UERF_IDX_DATA))
        next_q.readdata[7:0] = e.mem[e.rptr[2:0]];
      else if (hit(avs_address, `UERF_IDX_COUNT))
        next_q.readdata[7:0] = {4'h0, e.cnt};                   // [R3]
      else if (hit(avs_address, `UERF_IDX_CTRL))
        next_q.readdata[7:0] = {e.flush, 2'h0, e.rdone, 4'h0};
      else if (hit(avs_address, `UERF_IDX_FLAGS))
        next_q.readdata[7:0] = {4'h0, is_empty(e), e.full, e.urf, e.ovf}; // [R10]
      else if (hit(avs_address, `UERF_IDX_OVW))
        next_q.readdata[7:0] = {2'h0, e.setup_overwrite_start, e.setup_overwrite_end, 4'h0};
      else if (hit(avs_address, `UERF_IDX_EPSEL))
        next_q.readdata[`UERF_EP_W-1:0] = q.sel;
    end
    if (wr_ok && hit(avs_address, `UERF_IDX_EPSEL))
      next_q.sel = avs_writedata[`UERF_EP_W-1:0];
    for (int i = 0; i < `UERF_EPS; i++) begin
      e = q.ep[i];
      me = (q.sel == i[`UERF_EP_W-1:0]);                        // [R1]
      sme = (sil.ep == i[`UERF_EP_W-1:0]);
      // Firmware clears: writing zero clears a clear-only flag
      if (me && wr_ok && hit(avs_address, `UERF_IDX_FLAGS)) begin
        if (!avs_writedata[`UERF_FLG_URF]) e.urf = 1'b0;       // [R13]
        if (!avs_writedata[`UERF_FLG_OVF]) e.ovf = 1'b0;       // [R14]
      end
      if (me && wr_ok && hit(avs_address, `UERF_IDX_OVW) && !avs_writedata[`UERF_OVW_END])
        e.setup_overwrite_end = 1'b0;
      if (me && wr_ok && hit(avs_address, `UERF_IDX_CTRL)) begin
        if (avs_writedata[`UERF_CTRL_FLUSH]) e.flush = 1'b1;
        if (avs_writedata[`UERF_CTRL_DONE]) e.rdone = 1'b1;
      end
      // Read done releases the set unless a setup overwrite is under way
      if (q.ep[i].rdone) begin
        if (!q.ep[i].setup_overwrite_start && !q.ep[i].setup_overwrite_end) begin            // [R9]
          e.full = 1'b0;                                        // [R7]
          e.wptr = 4'h0;
          e.rptr = 4'h0;
        end
        e.rdone = 1'b0;                                         // [R7]
      end
      // CPU data read advances, or flags underrun and holds
      if (me && acc && avs_read && hit(avs_address, `UERF_IDX_DATA)) begin
        if (is_empty(q.ep[i]))
          e.urf = 1'b1;                                         // [R13]
        else if (!q.ep[i].setup_overwrite_start && !q.ep[i].setup_overwrite_end)
          e.rptr = q.ep[i].rptr + 4'h1;                         // [R2] [R19]
      end
      // Serial side byte write
      if (sme && sil.wr) begin
        if (q.ep[i].full)
          e.ovf = 1'b1;                                         // [R14] [R16]
        else if (q.ep[i].wptr < `UERF_PTR_FULL) begin           // [R21]
          e.mem[q.ep[i].wptr[2:0]] = sil.data;
          e.wptr = q.ep[i].wptr + 4'h1;                         // [R2]
        end
      end
      // Count write clears full; acknowledge sets it and wins
      if (sme && sil.cnt_wr) begin
        e.cnt = sil.cnt;                                        // [R4]
        e.full = 1'b0;                                          // [R5] [R12]
      end
      if (sme && sil.ack && !q.ep[i].setup_overwrite_start)
        e.full = 1'b1;                                          // [R11]
      // Setup token resets and locks the FIFO state
      if (sme && sil.setup) begin
        e.setup_overwrite_start = 1'b1;                                         // [R19]
        e.setup_overwrite_end = 1'b0;
        e.full = 1'b0;
        e.rptr = 4'h0;
        e.wptr = 4'h0;
        if (q.ep[i].ovf) e.ovf = 1'b0;                          // [R15]
      end
      if (sme && sil.setup_done && q.ep[i].setup_overwrite_start) begin
        e.setup_overwrite_start = 1'b0;
        e.setup_overwrite_end = 1'b1;
      end
      // Flush has the last word and then self clears
      if (q.ep[i].flush) begin
        e.wptr = 4'h0;                                          // [R6]
        e.rptr = 4'h0;
        e.full = 1'b0;
        e.urf = 1'b0;
        e.ovf = 1'b0;
        e.rdone = 1'b0;
        e.flush = 1'b0;
      end
      next_q.ep[i] = e;
      next_q.nak[i] = e.urf | e.ovf;                            // [R17]
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.waitrequest <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata    = q.readdata;
  assign avs_waitrequest = q.waitrequest;
  assign ep_nak          = q.nak;

  // Checks on endpoint 0, plus bus handshake, count read and the NAK of every endpoint
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic s0;
  logic cpu_rd0;
  assign s0 = (sil.ep == '0);
  assign cpu_rd0 = acc && avs_read && hit(avs_address, `UERF_IDX_DATA) && (q.sel == '0);

  // Byte written into a full FIFO is dropped and flagged; a same-cycle release would move the pointer
  property p_ovf_hold;
    s0 && sil.wr && q.ep[0].full && !q.ep[0].flush && !sil.setup && !q.ep[0].rdone
      |=> q.ep[0].ovf && $stable(q.ep[0].wptr);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overrun not flagged or pointer moved"); // [R14] [R16]

  // Read of an empty FIFO flags underrun and holds the read pointer
  property p_urf_hold;
    cpu_rd0 && is_empty(q.ep[0]) && !q.ep[0].flush && !q.ep[0].rdone && !(s0 && sil.setup)
      |=> q.ep[0].urf && $stable(q.ep[0].rptr);
  endproperty
  a_urf_hold: assert property (p_urf_hold) else $error("underrun not flagged or pointer moved"); // [R13]

  // Count write alone leaves the full flag clear
  property p_cnt_clr;
    s0 && sil.cnt_wr && !sil.ack |=> !q.ep[0].full;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("count write left full set"); // [R5] [R12]

  // Acknowledge outside a setup overwrite marks the set present
  property p_ack_full;
    s0 && sil.ack && !q.ep[0].setup_overwrite_start && !q.ep[0].flush && !sil.setup |=> q.ep[0].full;
  endproperty
  a_ack_full: assert property (p_ack_full) else $error("acknowledge did not set full"); // [R11]

  // Pending flush leaves an empty FIFO with full, underrun and overrun clear
  property p_flush;
    q.ep[0].flush |=> !q.ep[0].flush && !q.ep[0].full && !q.ep[0].urf && !q.ep[0].ovf
      && is_empty(q.ep[0]);
  endproperty
  a_flush: assert property (p_flush) else $error("flush left state behind"); // [R6]

  // An overrun raises NAK at the same edge as the flag
  property p_nak;
    s0 && sil.wr && q.ep[0].full && !q.ep[0].flush && !sil.setup |=> ep_nak[0];
  endproperty
  a_nak: assert property (p_nak) else $error("nak does not follow error flags"); // [R17]

  property p_done_locked;
    q.ep[0].rdone && (q.ep[0].setup_overwrite_start || q.ep[0].setup_overwrite_end) && !(s0 && (sil.cnt_wr || sil.ack || sil.setup))
      && !q.ep[0].flush |=> $stable(q.ep[0].full) && !q.ep[0].rdone;
  endproperty
  a_done_locked: assert property (p_done_locked) else $error("read done acted while locked"); // [R9]

  property p_setup;
    s0 && sil.setup && !q.ep[0].flush |=> q.ep[0].setup_overwrite_start && !q.ep[0].full && q.ep[0].rptr == 4'h0
      && !q.ep[0].ovf;
  endproperty
  a_setup: assert property (p_setup) else $error("setup did not reset and lock"); // [R19] [R15]

  property p_wr_adv;
    s0 && sil.wr && !q.ep[0].full && q.ep[0].wptr < `UERF_PTR_FULL && !sil.setup && !q.ep[0].flush
      && !q.ep[0].rdone |=> q.ep[0].wptr == $past(q.ep[0].wptr) + 4'h1;
  endproperty
  a_wr_adv: assert property (p_wr_adv) else $error("write pointer did not advance"); // [R2]

  property p_wait;
    (avs_read || avs_write) && q.waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("slave did not answer in one cycle"); // [R1]

  // Count register reads back with every bit above the four-bit count zero
  property p_cnt_upper;
    avs_read && q.waitrequest && hit(avs_address, `UERF_IDX_COUNT)
      |=> avs_readdata[31:4] == 28'h0;
  endproperty
  a_cnt_upper: assert property (p_cnt_upper) else $error("count register upper bits not zero"); // [R3]

  // Serial count write lands in the count of its endpoint
  property p_cnt_val;
    s0 && sil.cnt_wr |=> q.ep[0].cnt == $past(sil.cnt);
  endproperty
  a_cnt_val: assert property (p_cnt_val) else $error("byte count not stored"); // [R4]

  // Flag read of an endpoint with nothing written shows empty
  property p_empty_zero;
    avs_read && q.waitrequest && hit(avs_address, `UERF_IDX_FLAGS) && q.sel == '0
      && q.ep[0].wptr == 4'h0 |=> avs_readdata[`UERF_FLG_EMPTY];
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty flag missing on empty fifo"); // [R10]

  // Flag read with unread bytes left shows not empty
  property p_empty_data;
    avs_read && q.waitrequest && hit(avs_address, `UERF_IDX_FLAGS) && q.sel == '0
      && q.ep[0].wptr > q.ep[0].rptr |=> !avs_readdata[`UERF_FLG_EMPTY];
  endproperty
  a_empty_data: assert property (p_empty_data) else $error("empty flag set with data present"); // [R10]

  // Full flag reads back as it stands
  property p_full_read;
    avs_read && q.waitrequest && hit(avs_address, `UERF_IDX_FLAGS) && q.sel == '0
      |=> avs_readdata[`UERF_FLG_FULL] == $past(q.ep[0].full);
  endproperty
  a_full_read: assert property (p_full_read) else $error("full flag read back wrong"); // [R11]

  // Unlocked data read of a non-empty FIFO advances the read pointer by one
  property p_rd_adv;
    cpu_rd0 && !is_empty(q.ep[0]) && !q.ep[0].setup_overwrite_start && !q.ep[0].setup_overwrite_end && !q.ep[0].flush
      && !q.ep[0].rdone && !(s0 && sil.setup)
      |=> q.ep[0].rptr == $past(q.ep[0].rptr) + 4'h1;
  endproperty
  a_rd_adv: assert property (p_rd_adv) else $error("read pointer did not advance"); // [R2]

  // Data read during a setup overwrite must not disturb the read pointer
  property p_rd_locked;
    cpu_rd0 && (q.ep[0].setup_overwrite_start || q.ep[0].setup_overwrite_end) && !q.ep[0].flush && !(s0 && sil.setup)
      |=> $stable(q.ep[0].rptr);
  endproperty
  a_rd_locked: assert property (p_rd_locked) else $error("read pointer moved while locked"); // [R19]

  // Unlocked read done drops full and clears itself on the next edge
  property p_done_clear;
    q.ep[0].rdone && !q.ep[0].setup_overwrite_start && !q.ep[0].setup_overwrite_end && !(s0 && (sil.ack || sil.setup))
      |=> !q.ep[0].full && !q.ep[0].rdone;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("read done did not release the set"); // [R7]

  // Acknowledge during start overwrite cannot mark a set present
  property p_ack_locked;
    s0 && sil.ack && q.ep[0].setup_overwrite_start && !q.ep[0].full |=> !q.ep[0].full;
  endproperty
  a_ack_locked: assert property (p_ack_locked) else $error("full set while overwrite locked"); // [R5] [R19]

  // Writing zero to the underrun bit clears it
  property p_fw_urf;
    wr_ok && hit(avs_address, `UERF_IDX_FLAGS) && q.sel == '0 && !avs_writedata[`UERF_FLG_URF]
      |=> !q.ep[0].urf;
  endproperty
  a_fw_urf: assert property (p_fw_urf) else $error("underrun not cleared by firmware"); // [R13]

  // Writing zero to the overrun bit clears it unless a new overrun arrives
  property p_fw_ovf;
    wr_ok && hit(avs_address, `UERF_IDX_FLAGS) && q.sel == '0 && !avs_writedata[`UERF_FLG_OVF]
      && !(s0 && sil.wr) |=> !q.ep[0].ovf;
  endproperty
  a_fw_ovf: assert property (p_fw_ovf) else $error("overrun not cleared by firmware"); // [R14]

  // End of setup handshake hands the lock from start to end overwrite
  property p_setup_done;
    s0 && sil.setup_done && q.ep[0].setup_overwrite_start && !sil.setup |=> !q.ep[0].setup_overwrite_start && q.ep[0].setup_overwrite_end;
  endproperty
  a_setup_done: assert property (p_setup_done) else $error("overwrite lock not handed over"); // [R19] [R20]

  // A data read on another endpoint leaves this read pointer alone
  property p_sel_iso;
    acc && avs_read && hit(avs_address, `UERF_IDX_DATA) && q.sel != '0 && !q.ep[0].flush
      && !q.ep[0].rdone && !(s0 && sil.setup) |=> $stable(q.ep[0].rptr);
  endproperty
  a_sel_iso: assert property (p_sel_iso) else $error("read hit the unselected endpoint"); // [R1]

  // Every endpoint answers NAK exactly while one of its error flags stands
  for (genvar g = 0; g < `UERF_EPS; g++) begin : g_nak_chk
    property p_nak_ep;
      @(posedge mclk) disable iff (!nrst) ep_nak[g] == (q.ep[g].urf | q.ep[g].ovf);
    endproperty
    a_nak_ep: assert property (p_nak_ep) else $error("endpoint nak does not follow its flags"); // [R17]
  end
endmodule // uerf_rx_fifo
`default_nettype wire
